// File: design/rtp_top.sv
`default_nettype none
module rtp_top #(
	parameter int unsigned RT_HOLD  = rtp_pkg::RT_HOLD_CYC,
	parameter int unsigned GT_HOLD  = rtp_pkg::GT_HOLD_CYC,
	parameter int unsigned RMT_HOLD = rtp_pkg::RMT_HOLD_CYC
) (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_tach_pulse,
	input  wire logic        i_btn_pair_rt,
	input  wire logic        i_btn_pair_gt,
	input  wire logic        i_remote_reset_contact_a,
	input  wire logic        i_remote_reset_contact_b,
	input  wire logic        i_runtime_tick,
	input  wire logic [1:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [15:0] o_rdata,
	output logic [rtp_pkg::CNT_W-1:0] o_display,
	output logic             o_show_grand_total,
	output logic             o_output_switch_on,
	output logic             o_retransmit_indicator
);
	import rtp_pkg::*;

	// ----------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------
	logic [1:0] rst_sync_ff;
	logic       rst_n;
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n = rst_sync_ff[1];

	// Pins come from the outside world; first stage is read only by the second
	logic [4:0] pin_s1_ff;
	logic [4:0] pin_s2_ff;
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_ff <= 5'h00;
			pin_s2_ff <= 5'h00;
		end
		else
		begin
			pin_s1_ff <= {i_tach_pulse, i_btn_pair_rt, i_btn_pair_gt,
				i_remote_reset_contact_a, i_remote_reset_contact_b};
			pin_s2_ff <= pin_s1_ff;
		end
	end
	logic tach_s;
	logic btn_rt_s;
	logic btn_gt_s;
	logic rc_a_s;
	logic rc_b_s;
	logic remote_s;
	assign {tach_s, btn_rt_s, btn_gt_s, rc_a_s, rc_b_s} = pin_s2_ff;
	// Contacts joined only after both copies are synchronised, so no raw-pin glitch reaches the timer
	assign remote_s = rc_a_s & rc_b_s;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	rtp_mode_t   mode_ff;
	logic        loc_rt_en_ff;
	logic        loc_gt_en_ff;
	logic        out_en_ff;
	logic        scaled_ff;
	logic [2:0]  div_idx_ff;
	logic [2:0]  wid_idx_ff;
	logic [15:0] code_pend_ff;
	logic [15:0] code_act_ff;
	logic [15:0] entry_ff;
	logic [CNT_W-1:0] rt_cnt_ff;
	logic [CNT_W-1:0] gt_cnt_ff;

	logic wr_ctrl;
	logic wr_code;
	logic wr_cmd;
	logic in_disp;
	logic in_cfg;
	logic cmd_enter;
	logic cmd_exit;
	logic cmd_gt_clr;
	logic cmd_restore;
	logic rt_fire;
	logic gt_fire;
	logic rmt_fire;
	logic rt_clr;
	logic gt_clr;

	assign wr_ctrl     = i_wr && i_addr == REG_CTRL && in_cfg;
	assign wr_code     = i_wr && i_addr == REG_CODE;
	assign wr_cmd      = i_wr && i_addr == REG_CMD;
	assign in_disp     = mode_ff == MODE_DISPLAY;
	assign in_cfg      = mode_ff == MODE_CONFIG;
	// Command word: bit0 enter menu, bit1 back to display, bit2 clear total, bit3 accept restore
	assign cmd_enter   = wr_cmd && i_wdata[0] && !in_cfg;
	assign cmd_exit    = wr_cmd && i_wdata[1] && in_cfg;
	assign cmd_gt_clr  = wr_cmd && i_wdata[2] && in_cfg;                              // see [RQ7]
	assign cmd_restore = wr_cmd && i_wdata[3] && in_cfg && entry_ff == CONFIRM_WORD;  // see [RQ11]

	// Mode sequencing
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
			mode_ff <= MODE_DISPLAY;
		else if (cmd_restore || cmd_exit)
			mode_ff <= MODE_DISPLAY;
		else if (cmd_enter)
		begin
			if (code_act_ff == CODE_DEFAULT)
				mode_ff <= MODE_CONFIG;                                   // see [RQ9]
			else
				mode_ff <= MODE_LOCKED;
		end
		else if (mode_ff == MODE_LOCKED && wr_cmd && i_wdata[4])
			mode_ff <= (entry_ff == code_act_ff) ? MODE_CONFIG : MODE_DISPLAY; // see [RQ8]
	end

	// Digit entry: one nibble at a time, index in bits 9:8, value in 15:12
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
			entry_ff <= 16'h0000;
		else if (cmd_enter || cmd_exit || cmd_restore)
			entry_ff <= 16'h0000;
		else if (wr_cmd && i_wdata[5])
		begin
			unique case (i_wdata[9:8])
				2'h0: entry_ff[15:12] <= i_wdata[15:12];
				2'h1: entry_ff[11:8]  <= i_wdata[15:12];
				2'h2: entry_ff[7:4]   <= i_wdata[15:12];
				2'h3: entry_ff[3:0]   <= i_wdata[15:12];
			endcase // see [RQ8]
		end
	end

	// Security code: edited in menu, active on return to display
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			code_pend_ff <= CODE_DEFAULT;
			code_act_ff  <= CODE_DEFAULT;
		end
		else if (cmd_restore)
		begin
			code_pend_ff <= CODE_DEFAULT;
			code_act_ff  <= CODE_DEFAULT;
		end
		else
		begin
			if (wr_code && in_cfg)
				code_pend_ff <= i_wdata;
			if (cmd_exit)
				code_act_ff <= code_pend_ff; // see [RQ10]
		end
	end

	// Configuration bits; divisor and width only accepted while scaled
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			loc_rt_en_ff <= 1'b0;
			loc_gt_en_ff <= 1'b0;
			out_en_ff    <= 1'b0;
			scaled_ff    <= 1'b0;
			div_idx_ff   <= DIV_IDX_RST;
			wid_idx_ff   <= WID_IDX_RST;
		end
		else if (cmd_restore)
		begin
			loc_rt_en_ff <= 1'b0;
			loc_gt_en_ff <= 1'b0;
			out_en_ff    <= 1'b0;
			scaled_ff    <= 1'b0;
			div_idx_ff   <= DIV_IDX_RST;
			wid_idx_ff   <= WID_IDX_RST; // see [RQ11]
		end
		else if (wr_ctrl)
		begin
			loc_rt_en_ff <= i_wdata[0];
			loc_gt_en_ff <= i_wdata[1];
			out_en_ff    <= i_wdata[2];   // see [RQ12]
			scaled_ff    <= i_wdata[3];
			if (scaled_ff)
			begin
				div_idx_ff <= i_wdata[6:4]; // see [RQ16]
				wid_idx_ff <= i_wdata[10:8];
			end
		end
	end

	// ----------------------------------------
	// Hold timers and counters
	// ----------------------------------------
	rtp_hold_timer #(.HOLD_CYC(RT_HOLD)) u_rt_hold (
		.i_mclk  (i_mclk),
		.i_rst_n (rst_n),
		.i_hold  (btn_rt_s && in_disp && loc_rt_en_ff), // see [RQ1] [RQ2]
		.o_fire  (rt_fire)
	);
	rtp_hold_timer #(.HOLD_CYC(GT_HOLD)) u_gt_hold (
		.i_mclk  (i_mclk),
		.i_rst_n (rst_n),
		.i_hold  (btn_gt_s && in_disp && loc_gt_en_ff), // see [RQ1] [RQ5]
		.o_fire  (gt_fire)
	);
	rtp_hold_timer #(.HOLD_CYC(RMT_HOLD)) u_rmt_hold (
		.i_mclk  (i_mclk),
		.i_rst_n (rst_n),
		.i_hold  (remote_s),                            // see [RQ3]
		.o_fire  (rmt_fire)
	);

	assign rt_clr = rt_fire || rmt_fire;
	assign gt_clr = gt_fire || cmd_gt_clr;

	// Both counters advance on the same tick; clearing one leaves the other
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rt_cnt_ff <= '0;
			gt_cnt_ff <= '0;
		end
		else
		begin
			if (rt_clr)
				rt_cnt_ff <= '0;
			else if (i_runtime_tick)
				rt_cnt_ff <= rt_cnt_ff + 1'b1;
			if (gt_clr)
				gt_cnt_ff <= '0;                 // see [RQ4] [RQ7]
			else if (i_runtime_tick)
				gt_cnt_ff <= gt_cnt_ff + 1'b1;
		end
	end

	// Display selection
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_display          <= '0;
			o_show_grand_total <= 1'b0;
		end
		else
		begin
			o_show_grand_total <= in_disp && btn_gt_s;                    // see [RQ6]
			o_display          <= (in_disp && btn_gt_s) ? gt_cnt_ff : rt_cnt_ff;
		end
	end

	// Read port, data one cycle after strobe
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
			o_rdata <= 16'h0000;
		else if (i_rd)
		begin
			unique case (i_addr)
				REG_CTRL: o_rdata <= {5'h0, wid_idx_ff, 1'b0, div_idx_ff,
					scaled_ff, out_en_ff, loc_gt_en_ff, loc_rt_en_ff};
				REG_CODE: o_rdata <= in_cfg ? code_pend_ff : 16'h0000;
				REG_STAT: o_rdata <= {13'h0, mode_ff};
				REG_CMD:  o_rdata <= 16'h0000;
			endcase
		end
		else
			o_rdata <= 16'h0000;
	end

	// ----------------------------------------
	// Pulse output
	// ----------------------------------------
	rtp_cfg_if cfg_bus ();
	assign cfg_bus.out_en  = out_en_ff;
	assign cfg_bus.scaled  = scaled_ff;
	assign cfg_bus.div_idx = div_idx_ff;
	assign cfg_bus.wid_idx = wid_idx_ff;
	assign cfg_bus.flush   = gt_clr || rt_clr; // see [RQ20]

	rtp_pulse_eng u_eng (
		.i_mclk      (i_mclk),
		.i_rst_n     (rst_n),
		.i_pulse     (tach_s),
		.cfg         (cfg_bus.eng),
		.o_switch_on (o_output_switch_on),
		.o_indicator (o_retransmit_indicator)
	);

	// ----------------------------------------
	// Rule checks
	// ----------------------------------------
	a_gt_clear: assert property (@(posedge i_mclk) disable iff (!rst_n)
		gt_clr |=> gt_cnt_ff == '0) // see [RQ5] [RQ7]
		else $error("total not cleared");
	a_open_code: assert property (@(posedge i_mclk) disable iff (!rst_n)
		cmd_enter && code_act_ff == CODE_DEFAULT |=> mode_ff == MODE_CONFIG) // see [RQ9]
		else $error("default code did not open menu");
	a_wrong_code: assert property (@(posedge i_mclk) disable iff (!rst_n)
		mode_ff == MODE_LOCKED && wr_cmd && i_wdata[4] && !i_wdata[0] && entry_ff != code_act_ff
		|=> mode_ff == MODE_DISPLAY) // see [RQ8]
		else $error("wrong code opened menu");
	a_locked_stays: assert property (@(posedge i_mclk) disable iff (!rst_n)
		mode_ff == MODE_LOCKED && !(wr_cmd && (i_wdata[4] || i_wdata[0])) |=> mode_ff == MODE_LOCKED) // see [RQ8]
		else $error("locked state left without code");
	a_div_guard: assert property (@(posedge i_mclk) disable iff (!rst_n)
		wr_ctrl && !scaled_ff |=> div_idx_ff == $past(div_idx_ff) && wid_idx_ff == $past(wid_idx_ff)) // see [RQ16]
		else $error("divisor edited while direct");
	a_total_value: assert property (@(posedge i_mclk) disable iff (!rst_n)
		in_disp && btn_gt_s |=> o_display == $past(gt_cnt_ff)) // see [RQ6]
		else $error("total value not displayed");
	a_gt_survives: assert property (@(posedge i_mclk) disable iff (!rst_n)
		rt_clr && !gt_clr && !i_runtime_tick |=> gt_cnt_ff == $past(gt_cnt_ff)) // see [RQ4]
		else $error("total changed by run-time clear");
	a_rt_clear: assert property (@(posedge i_mclk) disable iff (!rst_n)
		rt_clr |=> rt_cnt_ff == '0) // see [RQ2] [RQ3]
		else $error("run-time not cleared");
	a_local_gated: assert property (@(posedge i_mclk) disable iff (!rst_n)
		rt_fire |-> $past(in_disp) && loc_rt_en_ff) // see [RQ1]
		else $error("local clear outside display");
	a_code_deferred: assert property (@(posedge i_mclk) disable iff (!rst_n)
		!cmd_exit && !cmd_restore |=> code_act_ff == $past(code_act_ff)) // see [RQ10]
		else $error("code activated early");
	a_restore_disp: assert property (@(posedge i_mclk) disable iff (!rst_n)
		cmd_restore |=> mode_ff == MODE_DISPLAY && !out_en_ff) // see [RQ11]
		else $error("restore incomplete");
	a_gt_shown: assert property (@(posedge i_mclk) disable iff (!rst_n)
		in_disp && btn_gt_s |=> o_show_grand_total) // see [RQ6]
		else $error("total not shown");
	c_remote_clr: cover property (@(posedge i_mclk) disable iff (!rst_n) rmt_fire);
	c_locked_entry: cover property (@(posedge i_mclk) disable iff (!rst_n) mode_ff == MODE_LOCKED);
	c_restore: cover property (@(posedge i_mclk) disable iff (!rst_n) cmd_restore);
endmodule
`default_nettype wire

// File: design/rtp_pkg.sv
// Notes on behaviour
// [RQ1] Local resets need enable and display mode
// [RQ2] Button pair held over 3 s clears run-time
// [RQ3] Remote contacts joined over 1 s clear run-time
// [RQ4] Grand total counts alongside, survives run-time clear
// [RQ5] Button pair held over 10 s clears total
// [RQ6] Total shown while assigned buttons held
// [RQ7] Menu command clears total, unrecoverable
// [RQ8] Menu entry needs matching four-digit code
// [RQ9] Default code grants access without asking
// [RQ10] New code activates on return to display
// [RQ11] Confirmation word then accept restores defaults
// [RQ12] Output enable gates without touching parameters
// [RQ13] Direct source copies input pulse
// [RQ14] Scaled source divides by one of five
// [RQ15] Scaled pulse width from fixed ms list
// [RQ16] Divisor and width editable only when scaled
// [RQ17] Scaled indicator lit while switch conducts
// [RQ18] Direct indicator lit continuously
// [RQ19] Pending pulses stored, emitted when width allows
// [RQ20] Pending count discarded on total clear
// [RQ21] Divisor and width lists are parameters
`default_nettype none
package rtp_pkg;
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned RT_HOLD_MS    = 3000;
	localparam int unsigned GT_HOLD_MS    = 10000;
	localparam int unsigned RMT_HOLD_MS   = 1000;
	localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
	localparam int unsigned RT_HOLD_CYC   = RT_HOLD_MS * CYC_PER_MS;
	localparam int unsigned GT_HOLD_CYC   = GT_HOLD_MS * CYC_PER_MS;
	localparam int unsigned RMT_HOLD_CYC  = RMT_HOLD_MS * CYC_PER_MS;
	localparam int unsigned CNT_W         = 32;
	localparam logic [15:0] CODE_DEFAULT  = 16'h0000;
	localparam logic [15:0] CONFIRM_WORD  = 16'h5AE1;
	localparam logic [2:0]  DIV_IDX_RST   = 3'h0;
	localparam logic [2:0]  WID_IDX_RST   = 3'h0;
	localparam logic [1:0]  ADDR_W        = 2'h3;
	localparam logic [1:0]  REG_CTRL      = 2'h0;
	localparam logic [1:0]  REG_CODE      = 2'h1;
	localparam logic [1:0]  REG_STAT      = 2'h2;
	localparam logic [1:0]  REG_CMD       = 2'h3;
	typedef enum logic [2:0] {
		MODE_DISPLAY = 3'b001,
		MODE_LOCKED  = 3'b010,
		MODE_CONFIG  = 3'b100
	} rtp_mode_t;
endpackage
`default_nettype wire

// File: design/rtp_cfg_if.sv
`default_nettype none
// Pulse output settings shared between the control top and the pulse engine
interface rtp_cfg_if;
	logic       out_en;
	logic       scaled;
	logic [2:0] div_idx;
	logic [2:0] wid_idx;
	logic       flush;
	modport ctrl (output out_en, output scaled, output div_idx, output wid_idx, output flush);
	modport eng  (input out_en, input scaled, input div_idx, input wid_idx, input flush);
endinterface
`default_nettype wire

// File: design/rtp_pulse_eng.sv
`default_nettype none
module rtp_pulse_eng #(
	parameter int unsigned DIV0 = 1,
	parameter int unsigned DIV1 = 10,
	parameter int unsigned DIV2 = 20,
	parameter int unsigned DIV3 = 50,
	parameter int unsigned DIV4 = 100,
	parameter int unsigned WID0 = 10,
	parameter int unsigned WID1 = 20,
	parameter int unsigned WID2 = 50,
	parameter int unsigned WID3 = 100,
	parameter int unsigned WID4 = 200
) (
	input  wire logic      i_mclk,
	input  wire logic      i_rst_n,
	input  wire logic      i_pulse,
	rtp_cfg_if.eng         cfg,
	output logic           o_switch_on,
	output logic           o_indicator
);
	import rtp_pkg::*;

	// ----------------------------------------
	// List lookups
	// ----------------------------------------
	// Index beyond the list falls back to the first entry
	function automatic logic [15:0] div_of(input logic [2:0] idx);
		unique case (idx)
			3'h1:    div_of = 16'(DIV1);
			3'h2:    div_of = 16'(DIV2);
			3'h3:    div_of = 16'(DIV3);
			3'h4:    div_of = 16'(DIV4);
			default: div_of = 16'(DIV0);
		endcase
	endfunction

	function automatic logic [31:0] wid_of(input logic [2:0] idx);
		unique case (idx)
			3'h1:    wid_of = 32'(WID1 * CYC_PER_MS);
			3'h2:    wid_of = 32'(WID2 * CYC_PER_MS);
			3'h3:    wid_of = 32'(WID3 * CYC_PER_MS);
			3'h4:    wid_of = 32'(WID4 * CYC_PER_MS);
			default: wid_of = 32'(WID0 * CYC_PER_MS);
		endcase
	endfunction // see [RQ21]

	logic        pulse_d_ff;
	logic [15:0] div_cnt_ff;
	logic [15:0] pend_ff;
	logic [31:0] wid_cnt_ff;
	logic        busy_ff;
	logic        rise;
	logic        tick;
	logic        start;

	assign rise  = i_pulse & ~pulse_d_ff;
	assign tick  = cfg.scaled && rise && (div_cnt_ff + 16'h0001 >= div_of(cfg.div_idx)); // see [RQ14]
	assign start = !busy_ff && (pend_ff != 16'h0000 || tick);

	// ----------------------------------------
	// Edge capture and divider
	// ----------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			pulse_d_ff <= 1'b0;
			div_cnt_ff <= 16'h0000;
		end
		else
		begin
			pulse_d_ff <= i_pulse;
			if (cfg.flush || !cfg.scaled)
				div_cnt_ff <= 16'h0000;
			else if (tick)
				div_cnt_ff <= 16'h0000;
			else if (rise)
				div_cnt_ff <= div_cnt_ff + 16'h0001;
		end
	end

	// Pending store: tick adds one, a started pulse takes one
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			pend_ff <= 16'h0000;
		else if (cfg.flush)
			pend_ff <= 16'h0000; // see [RQ20]
		else if (tick && !start)
			pend_ff <= (pend_ff == 16'hFFFF) ? pend_ff : pend_ff + 16'h0001; // see [RQ19]
		else if (start && !tick)
			pend_ff <= pend_ff - 16'h0001;
	end

	// Width stretcher
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			busy_ff    <= 1'b0;
			wid_cnt_ff <= 32'h0000_0000;
		end
		else if (!cfg.scaled)
		begin
			busy_ff    <= 1'b0;
			wid_cnt_ff <= 32'h0000_0000;
		end
		else if (start)
		begin
			busy_ff    <= 1'b1;
			wid_cnt_ff <= wid_of(cfg.wid_idx) - 32'h0000_0001; // see [RQ15]
		end
		else if (busy_ff)
		begin
			if (wid_cnt_ff == 32'h0000_0000)
				busy_ff <= 1'b0;
			else
				wid_cnt_ff <= wid_cnt_ff - 32'h0000_0001;
		end
	end

	// Output switch and indicator registered
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_switch_on <= 1'b0;
			o_indicator <= 1'b0;
		end
		else
		begin
			o_switch_on <= cfg.out_en && (cfg.scaled ? busy_ff : i_pulse); // see [RQ12] [RQ13]
			o_indicator <= cfg.out_en && (cfg.scaled ? busy_ff : 1'b1);    // see [RQ17] [RQ18]
		end
	end

	a_direct_copy: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		cfg.out_en && !cfg.scaled && $stable(cfg.scaled) |=> o_switch_on == $past(i_pulse)) // see [RQ13]
		else $error("direct output does not copy input");
	a_disabled_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		!cfg.out_en |=> !o_switch_on) // see [RQ12]
		else $error("disabled output conducts");
	a_scaled_ind: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		cfg.scaled && $past(cfg.scaled) |-> o_indicator == o_switch_on) // see [RQ17]
		else $error("indicator differs from switch");
	a_direct_ind: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		cfg.out_en && !cfg.scaled |=> o_indicator) // see [RQ18]
		else $error("direct indicator dark");
	a_pend_flush: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		cfg.flush |=> pend_ff == 16'h0000) // see [RQ20]
		else $error("pending count survives flush");
	c_scaled_pulse: cover property (@(posedge i_mclk) disable iff (!i_rst_n) cfg.scaled && start);
	c_backlog: cover property (@(posedge i_mclk) disable iff (!i_rst_n) pend_ff > 16'h0001);
endmodule
`default_nettype wire

// File: design/rtp_hold_timer.sv
`default_nettype none
module rtp_hold_timer #(
	parameter int unsigned HOLD_CYC = 40_000_000
) (
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	input  wire logic i_hold,
	output logic      o_fire
);
	import rtp_pkg::*;

	logic [31:0] cnt_ff;
	logic        done_ff;

	// Fires once after a continuous hold longer than HOLD_CYC; re-arms on release
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_ff  <= 32'h0000_0000;
			done_ff <= 1'b0;
		end
		else if (!i_hold)
		begin
			cnt_ff  <= 32'h0000_0000;
			done_ff <= 1'b0;
		end
		else if (!done_ff)
		begin
			if (cnt_ff >= 32'(HOLD_CYC))
				done_ff <= 1'b1;
			else
				cnt_ff <= cnt_ff + 32'h0000_0001;
		end
	end

	assign o_fire = i_hold && !done_ff && (cnt_ff >= 32'(HOLD_CYC));

	a_no_early_fire: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_fire |-> cnt_ff == 32'(HOLD_CYC))
		else $error("hold timer fired early");
endmodule
`default_nettype wire

// File: verif/rtp_remote_counter.sv
`default_nettype none
// ------------------------------------------------------------
// Remote counter with an open-collector input and a pull-up
// ------------------------------------------------------------
module rtp_remote_counter (
	input  wire logic        i_sw_on,
	output logic      [15:0] o_count
);
	timeunit 1ns;
	timeprecision 100ps;
	logic line_lvl;
	// Pull-up holds the line high whenever the switch is open
	assign line_lvl = i_sw_on ? 1'b0 : 1'b1;
	initial o_count = 16'h0000;
	// One count per conducting interval, taken at its leading edge
	always @(negedge line_lvl)
	begin
		o_count <= o_count + 16'h0001;
	end
endmodule
`default_nettype wire

// File: verif/runtime_reset_pulse_retransmit_test.sv
`default_nettype none
module runtime_reset_pulse_retransmit_test;
	timeunit 1ns;
	timeprecision 100ps;
	import rtp_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, tach = 1'b0, b_rt = 1'b0, b_gt = 1'b0;
	logic        rc_a = 1'b0, rc_b = 1'b0, tick = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [1:0]  addr = 2'h0;
	logic [15:0] wdata = 16'h0000, rdata, cnt, c0;
	logic [31:0] disp;
	logic        show, sw_on, ind;
	int          err_count = 0, check_count = 0;
	int unsigned divs[5] = '{1, 10, 20, 50, 100};
	// ------------------------------------------------------------
	// Clock, design and far-side counter
	// ------------------------------------------------------------
	always #12.5 clk = ~clk;
	// Short hold counts keep the run small; expectations use the same figures
	rtp_top #(.RT_HOLD(20), .GT_HOLD(50), .RMT_HOLD(10)) rtp_top_inst (
		.i_mclk(clk), .i_rst_n(rst_n), .i_tach_pulse(tach), .i_btn_pair_rt(b_rt),
		.i_btn_pair_gt(b_gt), .i_remote_reset_contact_a(rc_a), .i_remote_reset_contact_b(rc_b),
		.i_runtime_tick(tick), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .o_display(disp), .o_show_grand_total(show),
		.o_output_switch_on(sw_on), .o_retransmit_indicator(ind));
	rtp_remote_counter rtp_remote_counter_inst (.i_sw_on(sw_on), .o_count(cnt));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic do_reset();
		@(posedge clk) rst_n <= 1'b0;
		cyc(3);
		rst_n <= 1'b1;
		cyc(4);
	endtask
	task automatic bus_wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk) {wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk) wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [1:0] a, output logic [15:0] d);
		@(posedge clk) {rd, addr} <= {1'b1, a};
		@(posedge clk) rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp);
		logic [15:0] d;
		bus_rd(a, d);
		chk({16'h0000, d}, {16'h0000, exp});
	endtask
	// Loads a four-digit entry, most significant digit first
	task automatic load_digits(input logic [15:0] v);
		for (int i = 0; i < 4; i++)
			bus_wr(REG_CMD, {v[15-4*i -: 4], 2'b00, 2'(i), 8'h20});
	endtask
	// Enter the menu, write the control word, go back to display
	task automatic set_ctrl(input logic [15:0] v);
		bus_wr(REG_CMD, 16'h0001);
		bus_wr(REG_CTRL, v);
		bus_wr(REG_CMD, 16'h0002);
	endtask
	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge clk) tick <= 1'b1;
			@(posedge clk) tick <= 1'b0;
		end
	endtask
	// Holds one pin high for n cycles: 0 run-time pair, 1 contact a alone
	task automatic hold(input int sel, input int n);
		@(posedge clk);
		if (sel == 0)
			b_rt <= 1'b1;
		else
			rc_a <= 1'b1;
		cyc(n);
		b_rt <= 1'b0;
		rc_a <= 1'b0;
		cyc(6);
	endtask
	task automatic pulses(input int n);
		repeat (n)
		begin
			@(posedge clk) tach <= 1'b1;
			cyc(2);
			tach <= 1'b0;
			cyc(1);
		end
		cyc(8);
	endtask
	// Bounded wait for the switch to turn on; a miss ends the run
	task automatic wait_on();
		int k;
		for (k = 0; k < 20 && sw_on !== 1'b1; k++)
			@(posedge clk);
		chk({31'h0, sw_on}, 32'h1);
		if (sw_on !== 1'b1)
			report_and_stop();
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset_values();
		rd_chk(REG_STAT, 16'h0001);
		rd_chk(REG_CODE, 16'h0000);
		chk(disp, 32'h0);
		chk({30'h0, sw_on, ind}, 32'h0);
		$display("test reset_values done");
	endtask
	task automatic t_counters();
		ticks(5);
		hold(0, 40);
		chk(disp, 32'd5);
		@(posedge clk) b_gt <= 1'b1;
		cyc(80);
		chk({31'h0, show}, 32'h1);
		chk(disp, 32'd5);
		b_gt <= 1'b0;
		bus_wr(REG_CMD, 16'h0001);
		bus_wr(REG_CTRL, 16'h0003);
		hold(0, 40);
		bus_wr(REG_CMD, 16'h0002);
		cyc(4);
		chk(disp, 32'd5);
		hold(0, 40);
		chk(disp, 32'd0);
		@(posedge clk) b_gt <= 1'b1;
		cyc(10);
		chk(disp, 32'd5);
		b_gt <= 1'b0;
		ticks(3);
		@(posedge clk) {rc_a, rc_b} <= 2'b11;
		cyc(8);
		{rc_a, rc_b} <= 2'b00;
		cyc(6);
		chk(disp, 32'd3);
		hold(1, 2);
		@(posedge clk) {rc_a, rc_b} <= 2'b11;
		cyc(25);
		{rc_a, rc_b} <= 2'b00;
		cyc(6);
		chk(disp, 32'd0);
		@(posedge clk) b_gt <= 1'b1;
		cyc(80);
		chk(disp, 32'd0);
		b_gt <= 1'b0;
		ticks(2);
		bus_wr(REG_CMD, 16'h0001);
		bus_wr(REG_CMD, 16'h0004);
		bus_wr(REG_CMD, 16'h0002);
		@(posedge clk) b_gt <= 1'b1;
		cyc(10);
		chk(disp, 32'd0);
		b_gt <= 1'b0;
		cyc(6);
		chk(disp, 32'd2);
		$display("test counters done");
	endtask
	task automatic t_code();
		bus_wr(REG_CMD, 16'h0001);
		rd_chk(REG_STAT, 16'h0004);
		bus_wr(REG_CODE, 16'h1209);
		rd_chk(REG_CODE, 16'h1209);
		bus_wr(REG_CMD, 16'h0002);
		bus_wr(REG_CMD, 16'h0001);
		rd_chk(REG_STAT, 16'h0002);
		load_digits(16'h1208);
		bus_wr(REG_CMD, 16'h0010);
		rd_chk(REG_STAT, 16'h0001);
		bus_wr(REG_CMD, 16'h0001);
		load_digits(16'h1209);
		bus_wr(REG_CMD, 16'h0010);
		rd_chk(REG_STAT, 16'h0004);
		load_digits(16'h5AE0);
		bus_wr(REG_CMD, 16'h0008);
		rd_chk(REG_STAT, 16'h0004);
		load_digits(CONFIRM_WORD);
		bus_wr(REG_CMD, 16'h0008);
		rd_chk(REG_STAT, 16'h0001);
		bus_wr(REG_CMD, 16'h0001);
		rd_chk(REG_STAT, 16'h0004);
		bus_wr(REG_CMD, 16'h0002);
		$display("test code_and_restore done");
	endtask
	task automatic t_direct();
		set_ctrl(16'h0004);
		cyc(4);
		chk({31'h0, ind}, 32'h1);
		c0 = cnt;
		pulses(3);
		chk({16'h0, cnt}, {16'h0, c0 + 16'd3});
		set_ctrl(16'h0000);
		pulses(3);
		chk({16'h0, cnt}, {16'h0, c0 + 16'd3});
		$display("test direct done");
	endtask
	// Divisor field written while direct is still selected must be ignored
	task automatic t_div_locked();
		do_reset();
		set_ctrl(16'h001C);
		pulses(1);
		wait_on();
		chk({31'h0, ind}, 32'h1);
		// Input pulse is long over; a stretched pulse of whole milliseconds still conducts
		cyc(40);
		chk({31'h0, sw_on}, 32'h1);
		$display("test div_locked done");
	endtask
	task automatic t_divide();
		for (int i = 0; i < 5; i++)
		begin
			do_reset();
			bus_wr(REG_CMD, 16'h0001);
			bus_wr(REG_CTRL, 16'h000C);
			bus_wr(REG_CTRL, 16'h000C | (16'(i) << 4));
			bus_wr(REG_CMD, 16'h0002);
			pulses(divs[i] - 1);
			chk({30'h0, sw_on, ind}, 32'h0);
			pulses(1);
			wait_on();
			chk({31'h0, ind}, 32'h1);
		end
		$display("test divide done");
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		do_reset();
		t_reset_values();
		t_counters();
		t_code();
		t_direct();
		t_div_locked();
		t_divide();
		report_and_stop();
	end
endmodule
`default_nettype wire
